// ==== design/ucb_uart_front.sv ====
/*
 * UART configuration registers, runtime register map with divisor
 * overlay, double-buffered transmit and receive holding registers.
 * Assumes register strobes and serial input are synchronous to i_sys_clk;
 * source clocks arrive as one-cycle enables.
 */
`timescale 1ns/10ps
`default_nettype none
module ucb_uart_front
	import ucb_pkg::*;
(
	// Clock and resets
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_standby_reset_n,
	input wire logic i_system_reset_n,
	// Configuration port
	input wire logic i_cfg_wr,
	input wire logic i_cfg_rd,
	input wire logic [7:0] i_cfg_index,
	input wire logic [7:0] i_cfg_wdata,
	output logic [7:0] o_cfg_rdata,
	// Runtime port, host or EC
	input wire logic i_rt_wr,
	input wire logic i_rt_rd,
	input wire logic i_rt_from_ec,
	input wire logic [31:0] i_rt_addr,
	input wire logic [31:0] i_host_bar,
	input wire logic [7:0] i_rt_wdata,
	output logic [7:0] o_rt_rdata,
	output logic o_rt_ack,
	// Baud clock sources
	input wire logic i_tick_int_slow,
	input wire logic i_tick_int_fast,
	input wire logic i_tick_ext,
	// Serial pins
	input wire logic i_uart_rx,
	output logic o_uart_tx,
	output logic o_baud_clk
);

	// Whole state of the block
	typedef struct packed {
		logic act; // Device powered
		logic pol; // Pin inversion
		logic pwr; // Reset domain select
		logic clksrc; // External baud clock
		logic [7:0] dll; // Divisor low
		logic [7:0] dlh; // Clock select and divisor high
		logic [3:0] ier; // Interrupt enables, stored only
		logic [7:0] lcr; // Line control incl. access flag
		logic [7:0] mcr; // Modem control, stored only
		logic [7:0] scr; // Scratch
		logic [7:0] rbr; // Receive buffer
		logic dr; // Receive buffer full
		logic [7:0] thr; // Transmit buffer
		logic thr_full; // Transmit buffer waiting
		ucb_tx_e tx_st;
		logic [7:0] tx_sh;
		logic [2:0] tx_bit;
		logic [3:0] tx_os;
		logic tx_line; // Line level before inversion
		logic txo; // Registered pin
		ucb_rx_e rx_st;
		logic [7:0] rx_sh;
		logic [2:0] rx_bit;
		logic [3:0] rx_os;
		logic rx_q; // Registered, de-inverted receive pin
		logic [7:0] cfg_rdata;
		logic [7:0] rt_rdata;
		logic rt_ack;
	} ucb_state_s;

	ucb_state_s st_ff;
	ucb_state_s nxt_st;
	logic uart_rst; // Reset chosen by power select
	logic divisor_access_flag; // Divisor access flag
	logic [31:0] rt_base;
	logic [31:0] rt_off;
	logic rt_hit;
	logic [2:0] ofs;
	logic src_tick;
	logic div_reload;
	logic os_tick;
	logic [15:0] divisor;

	////////////////////////////////////////////////////////////////////////////
	// Reset domain, decode and clock source selection
	assign uart_rst = i_reset ||
		(st_ff.pwr ? !i_standby_reset_n : !i_system_reset_n);
	assign divisor_access_flag = st_ff.lcr[UCB_DIVISOR_ACCESS_FLAG_BIT];
	assign rt_base = i_rt_from_ec ? UCB_EC_RT_BASE : i_host_bar;
	assign rt_off = i_rt_addr - rt_base;
	// Powered-down device answers no runtime access
	assign rt_hit = st_ff.act && (rt_off < UCB_RT_SPAN);
	assign ofs = rt_off[2:0];
	assign src_tick = st_ff.clksrc ? i_tick_ext :
		(st_ff.dlh[UCB_FAST_CLK_BIT] ? i_tick_int_fast : i_tick_int_slow);
	// Bit 7 of the high byte is the clock select, not divisor
	assign divisor = {1'b0, st_ff.dlh[6:0], st_ff.dll};
	assign div_reload = uart_rst || !st_ff.act ||
		(i_rt_wr && rt_hit && divisor_access_flag && (ofs == UCB_RT_DATA || ofs == UCB_RT_IER));

	// Sixteen-times baud divider
	ucb_rate_div #(
		.W(16)
	) u_div (
		.i_sys_clk(i_sys_clk),
		.i_reset(i_reset),
		.i_src_tick(src_tick),
		.i_divisor(divisor),
		.i_reload(div_reload),
		.o_baud_level(o_baud_clk),
		.o_baud_tick(os_tick)
	);

	assign o_cfg_rdata = st_ff.cfg_rdata;
	assign o_rt_rdata = st_ff.rt_rdata;
	assign o_rt_ack = st_ff.rt_ack;
	assign o_uart_tx = st_ff.txo;

	////////////////////////////////////////////////////////////////////////////
	// Next state of registers, transmitter and receiver
	always_comb begin
		nxt_st = st_ff;
		nxt_st.rx_q = i_uart_rx ^ st_ff.pol;
		nxt_st.rt_ack = (i_rt_rd || i_rt_wr) && rt_hit;

		// Configuration writes: reserved bits are never stored
		if (i_cfg_wr && i_cfg_index == UCB_CFG_ACTIVATE) begin
			nxt_st.act = i_cfg_wdata[UCB_ACT_BIT];
		end
		if (i_cfg_wr && i_cfg_index == UCB_CFG_SELECT) begin
			nxt_st.pol = i_cfg_wdata[UCB_POL_BIT];
			nxt_st.pwr = i_cfg_wdata[UCB_PWR_BIT];
			nxt_st.clksrc = i_cfg_wdata[UCB_CLK_BIT];
		end
		// Configuration reads, reserved bits as zero
		if (i_cfg_rd) begin
			nxt_st.cfg_rdata = 8'h00;
			if (i_cfg_index == UCB_CFG_ACTIVATE) begin
				nxt_st.cfg_rdata[UCB_ACT_BIT] = st_ff.act;
			end else if (i_cfg_index == UCB_CFG_SELECT) begin
				nxt_st.cfg_rdata[UCB_POL_BIT] = st_ff.pol;
				nxt_st.cfg_rdata[UCB_PWR_BIT] = st_ff.pwr;
				nxt_st.cfg_rdata[UCB_CLK_BIT] = st_ff.clksrc;
			end
		end

		// Runtime writes; offset 0 and 1 follow the access flag
		if (i_rt_wr && rt_hit) begin
			unique case (ofs)
				UCB_RT_DATA: begin
					if (divisor_access_flag) begin
						nxt_st.dll = i_rt_wdata;
					end else begin
						// A write into a full buffer replaces the waiting byte
						nxt_st.thr = i_rt_wdata;
						nxt_st.thr_full = 1'b1;
					end
				end
				UCB_RT_IER: begin
					if (divisor_access_flag) begin
						nxt_st.dlh = i_rt_wdata;
					end else begin
						nxt_st.ier = i_rt_wdata[3:0] & UCB_IER_MASK[3:0];
					end
				end
				UCB_RT_LCR: nxt_st.lcr = i_rt_wdata;
				UCB_RT_MCR: nxt_st.mcr = i_rt_wdata;
				UCB_RT_SCR: nxt_st.scr = i_rt_wdata;
				default: begin
					// Control and status offsets ignore writes here
				end
			endcase
		end

		// Runtime reads, data registered
		if (i_rt_rd && rt_hit) begin
			unique case (ofs)
				UCB_RT_DATA: begin
					nxt_st.rt_rdata = divisor_access_flag ? st_ff.dll : st_ff.rbr;
					if (!divisor_access_flag) begin
						nxt_st.dr = 1'b0;
					end
				end
				UCB_RT_IER: nxt_st.rt_rdata = divisor_access_flag ? st_ff.dlh : {4'h0, st_ff.ier};
				UCB_RT_IIR: nxt_st.rt_rdata = UCB_IIR_NONE;
				UCB_RT_LCR: nxt_st.rt_rdata = st_ff.lcr;
				UCB_RT_MCR: nxt_st.rt_rdata = st_ff.mcr;
				UCB_RT_LSR: begin
					nxt_st.rt_rdata = 8'h00;
					nxt_st.rt_rdata[UCB_LSR_DR] = st_ff.dr;
					nxt_st.rt_rdata[UCB_LSR_THRE] = !st_ff.thr_full;
					nxt_st.rt_rdata[UCB_LSR_TEMT] = !st_ff.thr_full &&
						(st_ff.tx_st == UCB_TX_IDLE);
				end
				UCB_RT_MSR: nxt_st.rt_rdata = 8'h00;
				UCB_RT_SCR: nxt_st.rt_rdata = st_ff.scr;
				default: nxt_st.rt_rdata = 8'h00;
			endcase
		end

		// Transmitter: shift register takes the buffer only when idle
		unique case (st_ff.tx_st)
			UCB_TX_IDLE: begin
				nxt_st.tx_line = 1'b1;
				if (st_ff.thr_full && st_ff.act) begin
					nxt_st.tx_sh = st_ff.thr;
					nxt_st.thr_full = (i_rt_wr && rt_hit && !divisor_access_flag && ofs == UCB_RT_DATA);
					nxt_st.tx_os = 4'h0;
					nxt_st.tx_bit = 3'h0;
					nxt_st.tx_line = 1'b0;
					nxt_st.tx_st = UCB_TX_START;
				end
			end
			UCB_TX_START, UCB_TX_DATA, UCB_TX_STOP: begin
				if (os_tick) begin
					nxt_st.tx_os = st_ff.tx_os + 4'h1;
					if (st_ff.tx_os == UCB_OS_LAST) begin
						if (st_ff.tx_st == UCB_TX_START) begin
							nxt_st.tx_line = st_ff.tx_sh[0];
							nxt_st.tx_st = UCB_TX_DATA;
						end else if (st_ff.tx_st == UCB_TX_DATA) begin
							if (st_ff.tx_bit == UCB_LAST_BIT) begin
								nxt_st.tx_line = 1'b1;
								nxt_st.tx_st = UCB_TX_STOP;
							end else begin
								nxt_st.tx_sh = {1'b0, st_ff.tx_sh[7:1]};
								nxt_st.tx_line = st_ff.tx_sh[1];
								nxt_st.tx_bit = st_ff.tx_bit + 3'h1;
							end
						end else begin
							// Stop bit done, next character may load
							nxt_st.tx_st = UCB_TX_IDLE;
						end
					end
				end
			end
			default: nxt_st.tx_st = UCB_TX_IDLE;
		endcase

		// Receiver: start confirmed mid-bit, then sampled every 16 ticks
		unique case (st_ff.rx_st)
			UCB_RX_IDLE: begin
				if (os_tick && !st_ff.rx_q) begin
					nxt_st.rx_os = 4'h0;
					nxt_st.rx_st = UCB_RX_START;
				end
			end
			UCB_RX_START, UCB_RX_DATA, UCB_RX_STOP: begin
				if (os_tick) begin
					nxt_st.rx_os = st_ff.rx_os + 4'h1;
					if (st_ff.rx_st == UCB_RX_START && st_ff.rx_os == UCB_OS_MID) begin
						// A glitch shorter than half a bit is dropped
						nxt_st.rx_st = st_ff.rx_q ? UCB_RX_IDLE : UCB_RX_DATA;
						nxt_st.rx_os = 4'h0;
						nxt_st.rx_bit = 3'h0;
					end else if (st_ff.rx_st == UCB_RX_DATA && st_ff.rx_os == UCB_OS_LAST) begin
						nxt_st.rx_sh = {st_ff.rx_q, st_ff.rx_sh[7:1]};
						nxt_st.rx_bit = st_ff.rx_bit + 3'h1;
						if (st_ff.rx_bit == UCB_LAST_BIT) begin
							nxt_st.rx_st = UCB_RX_STOP;
						end
					end else if (st_ff.rx_st == UCB_RX_STOP && st_ff.rx_os == UCB_OS_LAST) begin
						// Transfer wins over a same-cycle read clear
						nxt_st.rbr = st_ff.rx_sh;
						nxt_st.dr = 1'b1;
						nxt_st.rx_st = UCB_RX_IDLE;
					end
				end
			end
			default: nxt_st.rx_st = UCB_RX_IDLE;
		endcase

		// Powered down: engines idle, line at mark
		if (!st_ff.act) begin
			nxt_st.tx_st = UCB_TX_IDLE;
			nxt_st.rx_st = UCB_RX_IDLE;
			nxt_st.tx_line = 1'b1;
		end
		nxt_st.txo = nxt_st.tx_line ^ st_ff.pol;

		// Runtime reset from selected domain
		if (uart_rst) begin
			nxt_st.dll = 8'h00;
			nxt_st.dlh = 8'h00;
			nxt_st.ier = 4'h0;
			nxt_st.lcr = 8'h00;
			nxt_st.mcr = 8'h00;
			nxt_st.scr = 8'h00;
			nxt_st.rbr = 8'h00;
			nxt_st.dr = 1'b0;
			nxt_st.thr = 8'h00;
			nxt_st.thr_full = 1'b0;
			nxt_st.tx_st = UCB_TX_IDLE;
			nxt_st.tx_sh = 8'h00;
			nxt_st.tx_bit = 3'h0;
			nxt_st.tx_os = 4'h0;
			nxt_st.tx_line = 1'b1;
			nxt_st.txo = !st_ff.pol;
			nxt_st.rx_st = UCB_RX_IDLE;
			nxt_st.rx_sh = 8'h00;
			nxt_st.rx_bit = 3'h0;
			nxt_st.rx_os = 4'h0;
			nxt_st.rt_rdata = 8'h00;
			nxt_st.rt_ack = 1'b0;
		end
		// Configuration reset
		if (i_reset) begin
			nxt_st.act = 1'b0;
			nxt_st.pol = 1'b0;
			nxt_st.pwr = UCB_PWR_RESET;
			nxt_st.clksrc = 1'b0;
			nxt_st.cfg_rdata = 8'h00;
			nxt_st.txo = 1'b1;
			nxt_st.rx_q = 1'b1;
		end
	end

	// State register
	always_ff @(posedge i_sys_clk) begin
		st_ff <= nxt_st;
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	AST_ACT_READ: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(i_cfg_rd && i_cfg_index == UCB_CFG_ACTIVATE) |=> o_cfg_rdata == {7'h00, $past(st_ff.act)})
		else $error("activate read wrong");
	AST_IDLE_POL: assert property (@(posedge i_sys_clk) disable iff (uart_rst)
		(st_ff.tx_st == UCB_TX_IDLE && !(st_ff.thr_full && st_ff.act)) |=>
		o_uart_tx == !$past(st_ff.pol))
		else $error("idle line polarity wrong");
	AST_PWR_DEFAULT: assert property (@(posedge i_sys_clk)
		i_reset ##1 !i_reset ##1
		(i_cfg_rd && i_cfg_index == UCB_CFG_SELECT && !i_reset) |=>
		o_cfg_rdata == 8'h02)
		else $error("select register reset value wrong");
	AST_EXT_SRC: assert property (@(posedge i_sys_clk) disable iff (uart_rst)
		(st_ff.clksrc && !i_tick_ext) |-> !os_tick)
		else $error("baud tick without external source tick");
	AST_DIVISOR_ACCESS_FLAG_LOW: assert property (@(posedge i_sys_clk) disable iff (uart_rst)
		(i_rt_wr && rt_hit && divisor_access_flag && ofs == UCB_RT_DATA) |=>
		st_ff.dll == $past(i_rt_wdata) && st_ff.thr == $past(st_ff.thr))
		else $error("divisor low write misrouted");
	AST_RBR_READ: assert property (@(posedge i_sys_clk) disable iff (uart_rst)
		(i_rt_rd && rt_hit && !divisor_access_flag && ofs == UCB_RT_DATA) |=>
		o_rt_rdata == $past(st_ff.rbr) && o_rt_ack)
		else $error("receive buffer read wrong");
	AST_LSB_FIRST: assert property (@(posedge i_sys_clk) disable iff (uart_rst || !st_ff.act)
		(st_ff.tx_st == UCB_TX_START && os_tick && st_ff.tx_os == UCB_OS_LAST) |=>
		o_uart_tx == ($past(st_ff.tx_sh[0]) ^ st_ff.pol))
		else $error("first data bit is not bit 0");
	AST_RX_XFER: assert property (@(posedge i_sys_clk) disable iff (uart_rst || !st_ff.act)
		(st_ff.rx_st == UCB_RX_STOP && os_tick && st_ff.rx_os == UCB_OS_LAST) |=>
		st_ff.dr && st_ff.rbr == $past(st_ff.rx_sh))
		else $error("receive transfer missing");
	AST_TX_HOLD: assert property (@(posedge i_sys_clk) disable iff (uart_rst)
		(st_ff.thr_full && st_ff.tx_st != UCB_TX_IDLE) |=> st_ff.thr_full)
		else $error("buffer taken while shifting");
	AST_EC_BASE: assert property (@(posedge i_sys_clk) disable iff (uart_rst)
		(i_rt_rd && i_rt_from_ec && i_rt_addr == UCB_EC_RT_BASE && st_ff.act) |=> o_rt_ack)
		else $error("EC base not decoded");
	COV_TX_DONE: cover property (@(posedge i_sys_clk) disable iff (uart_rst)
		st_ff.tx_st == UCB_TX_STOP ##1 st_ff.tx_st == UCB_TX_IDLE);
	COV_RX_CHAR: cover property (@(posedge i_sys_clk) disable iff (uart_rst)
		!$past(st_ff.dr) && st_ff.dr);
	COV_DLH_WRITE: cover property (@(posedge i_sys_clk) disable iff (uart_rst)
		i_rt_wr && rt_hit && divisor_access_flag && ofs == UCB_RT_IER);

endmodule
`default_nettype wire

// ==== design/ucb_pkg.sv ====
/*
 * Constants, field positions and state encodings shared by the UART
 * configuration and holding-register front end and its baud divider.
 * Assumes one 250 MHz system clock and byte-wide register ports.
 */
// What this block does
// - Activate bit 30h[0] powers the UART
// - Select bit F0h[2] inverts transmit and receive
// - Select bit 1 picks standby or system reset
// - Select bit 0 picks external baud clock
// - Line control bit 7 is divisor access flag
// - Flag set: offsets 0/1 reach divisor bytes
// - Characters travel least significant bit first
// - Receive shift register feeds readable receive buffer
// - Transmit shift loads only after previous character
// - Offset 0: write transmit, read receive buffer
// - Divisor low byte read/write, resets zero
// - Runtime registers at host BAR, EC base
// - Divider yields sixteen times the bit rate
// - Divisor byte write reloads the baud counter
// - Divisor 0 divides by three, 1 inverts
// - Divisor high bit 7 picks fast internal clock
package ucb_pkg;

	// Configuration space indices and field positions
	localparam logic [7:0] UCB_CFG_ACTIVATE = 8'h30;
	localparam logic [7:0] UCB_CFG_SELECT = 8'hF0;
	localparam int UCB_ACT_BIT = 0;
	localparam int UCB_POL_BIT = 2;
	localparam int UCB_PWR_BIT = 1;
	localparam int UCB_CLK_BIT = 0;
	localparam logic UCB_PWR_RESET = 1'h1;

	// Runtime register offsets
	localparam logic [2:0] UCB_RT_DATA = 3'h0;
	localparam logic [2:0] UCB_RT_IER = 3'h1;
	localparam logic [2:0] UCB_RT_IIR = 3'h2;
	localparam logic [2:0] UCB_RT_LCR = 3'h3;
	localparam logic [2:0] UCB_RT_MCR = 3'h4;
	localparam logic [2:0] UCB_RT_LSR = 3'h5;
	localparam logic [2:0] UCB_RT_MSR = 3'h6;
	localparam logic [2:0] UCB_RT_SCR = 3'h7;
	localparam logic [31:0] UCB_RT_SPAN = 32'h0000_0008;
	localparam logic [31:0] UCB_EC_RT_BASE = 32'h000F_1C00;

	// Runtime field positions and fixed values
	localparam int UCB_DIVISOR_ACCESS_FLAG_BIT = 7;
	localparam int UCB_FAST_CLK_BIT = 7;
	localparam logic [7:0] UCB_IER_MASK = 8'h0F;
	localparam logic [7:0] UCB_IIR_NONE = 8'h01;
	localparam int UCB_LSR_DR = 0;
	localparam int UCB_LSR_THRE = 5;
	localparam int UCB_LSR_TEMT = 6;

	// Serial timing in sixteenth-bit ticks
	localparam logic [3:0] UCB_OS_LAST = 4'hF;
	localparam logic [3:0] UCB_OS_MID = 4'h7;
	localparam logic [2:0] UCB_LAST_BIT = 3'h7;
	localparam logic [15:0] UCB_DIV_ZERO_PERIOD = 16'h0003;
	localparam logic [15:0] UCB_LOW_COUNTS = 16'h0002;

	// Transmit and receive engine states, one-hot
	typedef enum logic [3:0] {
		UCB_TX_IDLE = 4'b0001,
		UCB_TX_START = 4'b0010,
		UCB_TX_DATA = 4'b0100,
		UCB_TX_STOP = 4'b1000
	} ucb_tx_e;

	typedef enum logic [3:0] {
		UCB_RX_IDLE = 4'b0001,
		UCB_RX_START = 4'b0010,
		UCB_RX_DATA = 4'b0100,
		UCB_RX_STOP = 4'b1000
	} ucb_rx_e;

endpackage

// ==== design/ucb_rate_div.sv ====
/*
 * Baud divider: counts source-clock ticks and emits the sixteen-times
 * bit-rate clock level plus a one-cycle tick per output period.
 * Assumes the source clock arrives as a one-cycle enable per period.
 */
`timescale 1ns/10ps
`default_nettype none
module ucb_rate_div
	import ucb_pkg::*;
#(
	parameter int W = 16
) (
	// Clock and hold
	input wire logic i_sys_clk,
	input wire logic i_reset,
	// Source and divisor
	input wire logic i_src_tick,
	input wire logic [W-1:0] i_divisor,
	input wire logic i_reload,
	// Divided clock
	output logic o_baud_level,
	output logic o_baud_tick
);

	// Counter and output level
	typedef struct packed {
		logic [W-1:0] cnt;
		logic lvl;
	} ucb_div_s;

	ucb_div_s st_ff;
	ucb_div_s nxt_st;
	logic [W-1:0] period; // Zero divisor behaves as three

	assign period = (i_divisor == '0) ? W'(UCB_DIV_ZERO_PERIOD) : i_divisor;
	assign o_baud_tick = i_src_tick && (st_ff.cnt == '0) && !i_reload;
	assign o_baud_level = st_ff.lvl;

	////////////////////////////////////////////////////////////////////////////
	// Next-state: reload on divisor write, from the divisor as it stood before the write
	always_comb begin
		nxt_st = st_ff;
		if (i_reset || i_reload) begin
			nxt_st.cnt = period - W'(1);
			nxt_st.lvl = 1'b0;
		end else if (i_src_tick) begin
			nxt_st.cnt = (st_ff.cnt == '0) ? period - W'(1) : st_ff.cnt - W'(1);
			if (period <= W'(2)) begin
				// One or two: toggling gives the inverse or a 50% halving
				nxt_st.lvl = !st_ff.lvl;
			end else begin
				// Low for two counts, high for the rest
				nxt_st.lvl = (nxt_st.cnt < period - W'(UCB_LOW_COUNTS));
			end
		end
		// Divide by one: level is the inverse of the source enable; a source
		// faster than half the system clock cannot be shown this way
		if (!i_reset && !i_reload && period == W'(1)) begin
			nxt_st.lvl = !i_src_tick;
		end
	end

	// State register
	always_ff @(posedge i_sys_clk) begin
		st_ff <= nxt_st;
	end

	AST_RELOAD: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		i_reload |=> st_ff.cnt == $past(period) - W'(1))
		else $error("divisor write did not reload counter");
	AST_DIV_ZERO: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(i_reload && i_divisor == '0) |=> st_ff.cnt == W'(2))
		else $error("zero divisor not treated as three");
	COV_DIV_TICK: cover property (@(posedge i_sys_clk) disable iff (i_reset) o_baud_tick);

endmodule
`default_nettype wire

// ==== dv/ucb_serial_peer.sv ====
/*
 * Serial peer model: decodes the transmit line and sends characters
 * on the receive line. Assumes a fixed bit time counted in system clocks.
 */
`timescale 1ns/10ps
`default_nettype none
module ucb_serial_peer #(
	parameter int BIT_CLKS = 64
) (
	// Clock
	input wire logic i_sys_clk,
	// Line polarity and pins
	input wire logic i_invert,
	input wire logic i_tx,
	output logic o_rx,
	// Decoded characters
	output logic [7:0] o_byte,
	output int o_count
);
	logic [7:0] shift_ff;
	logic line_ff;
	// Idle level is mark; follows the polarity setting
	assign o_rx = line_ff ^ i_invert;
	initial begin
		line_ff = 1'b1;
		o_byte = 8'h00;
		o_count = 0;
	end
	// Receiver: mid-bit sampling, least significant bit first
	always begin
		@(posedge i_sys_clk);
		if ((i_tx ^ i_invert) === 1'b0) begin
			repeat (BIT_CLKS / 2) @(posedge i_sys_clk);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CLKS) @(posedge i_sys_clk);
				shift_ff[i] = i_tx ^ i_invert;
			end
			// Skip to mid stop bit so a low bit 7 is not taken as a start
			repeat (BIT_CLKS) @(posedge i_sys_clk);
			o_byte = shift_ff;
			o_count = o_count + 1;
		end
	end
	// Sender: start, eight data bits first bit 0, stop
	task automatic send(input logic [7:0] data);
		logic [9:0] frame;
		frame = {1'b1, data, 1'b0};
		for (int i = 0; i < 10; i++) begin
			line_ff <= frame[i];
			repeat (BIT_CLKS) @(posedge i_sys_clk);
		end
	endtask
endmodule
`default_nettype wire

// ==== dv/uart_config_and_buffer_regs_tb.sv ====
/*
 * Testbench for the UART front end: config and runtime register tasks,
 * divider rate checks and serial traffic with a peer model.
 * Assumes the external tick runs every clock, giving 64 clocks a bit.
 */
`timescale 1ns/10ps
`default_nettype none
module uart_config_and_buffer_regs_tb;
	import ucb_pkg::*;
	logic clk, rst, sb_n, sys_n, cfg_wr, cfg_rd, rt_wr, rt_rd, rt_ec;
	logic [7:0] cfg_idx, cfg_wd, cfg_q, rt_wd, rt_q, d, c;
	logic [31:0] rt_addr, bar;
	logic rt_ack, fast, slow, ext, rx, tx, baud, inv, a;
	logic [7:0] pbyte;
	int pcount, fails, n_compared, cycles, base;
	ucb_uart_front ucb_uart_front_i (.i_sys_clk(clk), .i_reset(rst),
		.i_standby_reset_n(sb_n), .i_system_reset_n(sys_n), .i_cfg_wr(cfg_wr),
		.i_cfg_rd(cfg_rd), .i_cfg_index(cfg_idx), .i_cfg_wdata(cfg_wd),
		.o_cfg_rdata(cfg_q), .i_rt_wr(rt_wr), .i_rt_rd(rt_rd), .i_rt_from_ec(rt_ec),
		.i_rt_addr(rt_addr), .i_host_bar(bar), .i_rt_wdata(rt_wd), .o_rt_rdata(rt_q),
		.o_rt_ack(rt_ack), .i_tick_int_slow(slow), .i_tick_int_fast(fast),
		.i_tick_ext(ext), .i_uart_rx(rx), .o_uart_tx(tx), .o_baud_clk(baud));
	ucb_serial_peer ucb_serial_peer_i (.i_sys_clk(clk), .i_invert(inv), .i_tx(tx),
		.o_rx(rx), .o_byte(pbyte), .o_count(pcount));
	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Config access: strobe one cycle, data settles after the taking edge
	task automatic cfg(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		@(posedge clk);
		cfg_wr <= wr;
		cfg_rd <= !wr;
		cfg_idx <= idx;
		cfg_wd <= wd;
		@(posedge clk);
		cfg_wr <= 1'b0;
		cfg_rd <= 1'b0;
		@(negedge clk);
	endtask
	task automatic cr(input logic [7:0] idx, input logic [7:0] exp);
		cfg(1'b0, idx, 8'h00);
		check("cfg", exp, cfg_q);
	endtask
	// Runtime access; ack and read data stand in the cycle after
	task automatic rt(input logic wr, input logic ec, input logic [31:0] off,
		input logic [7:0] wd);
		@(posedge clk);
		rt_wr <= wr;
		rt_rd <= !wr;
		rt_ec <= ec;
		rt_addr <= (ec ? UCB_EC_RT_BASE : bar) + off;
		rt_wd <= wd;
		@(posedge clk);
		rt_wr <= 1'b0;
		rt_rd <= 1'b0;
		@(negedge clk);
		d = rt_q;
		a = rt_ack;
	endtask
	task automatic rr(input logic [31:0] off, input logic [7:0] exp);
		rt(1'b0, 1'b0, off, 8'h00);
		check("rt_data", exp, d);
		check("rt_ack", 8'h01, {7'h00, a});
	endtask
	// Divisor load goes through the access flag and clears it again
	task automatic setdiv(input logic [7:0] hi, input logic [7:0] lo);
		rt(1'b1, 1'b0, 3, 8'h80);
		rt(1'b1, 1'b0, 0, lo);
		rt(1'b1, 1'b0, 1, hi);
		rt(1'b1, 1'b0, 3, 8'h03);
	endtask
	// Count rising edges of the divided clock over n cycles
	task automatic rises(input int n, input logic [7:0] exp);
		logic prev;
		c = 8'h00;
		prev = baud;
		repeat (n) begin
			@(posedge clk);
			#1;
			if (baud && !prev) c++;
			prev = baud;
		end
		check("baud_rises", exp, c);
	endtask
	// Bounded wait for the peer to decode n characters
	task automatic wait_peer(input int n, input logic [7:0] exp);
		for (int i = 0; i < 2000 && pcount < n; i++) @(posedge clk);
		check("peer_byte", exp, pbyte);
	endtask
	task automatic wrap_up();
		$display("compared %0d mismatched %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Hang guard: the tests need well under 12000 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			wrap_up();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		{cfg_wr, cfg_rd, rt_wr, rt_rd, rt_ec, fast, slow, inv} = '0;
		{cfg_idx, cfg_wd, rt_wd, rt_addr} = '0;
		{rst, sb_n, sys_n, ext} = 4'hF;
		bar = 32'h0000_0200;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		cr(8'hF0, 8'h02);
		cr(8'h30, 8'h00);
		rt(1'b0, 1'b0, 7, 8'h00);
		check("ack_off", 8'h00, {7'h00, a});
		cfg(1'b1, 8'h30, 8'hFF);
		cr(8'h30, 8'h01);
		cfg(1'b1, 8'hF0, 8'hF8);
		cr(8'hF0, 8'h00);
		cfg(1'b1, 8'hF0, 8'h03);
		cr(8'hF0, 8'h03);
		$display("test config done");
		setdiv(8'h00, 8'h04);
		rt(1'b1, 1'b0, 3, 8'h80);
		rr(0, 8'h04);
		rr(1, 8'h00);
		rt(1'b1, 1'b0, 3, 8'h03);
		rt(1'b1, 1'b0, 1, 8'hFF);
		rr(1, 8'h0F);
		rr(3, 8'h03);
		rt(1'b1, 1'b1, 7, 8'h5A);
		rt(1'b0, 1'b1, 7, 8'h00);
		check("ec_scratch", 8'h5A, d);
		rt(1'b0, 1'b1, 0, 8'h00);
		check("ec_ack", 8'h01, {7'h00, a});
		rt(1'b0, 1'b0, 8, 8'h00);
		check("ack_range", 8'h00, {7'h00, a});
		$display("test registers done");
		setdiv(8'h00, 8'h00);
		rises(240, 8'h50);
		setdiv(8'h00, 8'h02);
		rises(240, 8'h78);
		setdiv(8'h00, 8'h04);
		rises(240, 8'h3C);
		ext <= 1'b0;
		rises(240, 8'h00);
		ext <= 1'b1;
		cfg(1'b1, 8'hF0, 8'h02);
		fast <= 1'b1;
		setdiv(8'h80, 8'h04);
		rises(240, 8'h3C);
		{fast, slow} <= 2'b01;
		setdiv(8'h00, 8'h04);
		rises(240, 8'h3C);
		slow <= 1'b0;
		cfg(1'b1, 8'hF0, 8'h03);
		$display("test divider done");
		base = pcount;
		rt(1'b1, 1'b0, 0, 8'hA5);
		rt(1'b1, 1'b0, 0, 8'h3C);
		rr(0, 8'h00);
		wait_peer(base + 1, 8'hA5);
		wait_peer(base + 2, 8'h3C);
		$display("test transmit done");
		ucb_serial_peer_i.send(8'h5A);
		repeat (40) @(posedge clk);
		rr(5, 8'h61);
		rr(0, 8'h5A);
		rr(5, 8'h60);
		$display("test receive done");
		cfg(1'b1, 8'hF0, 8'h07);
		inv <= 1'b1;
		repeat (800) @(posedge clk);
		base = pcount;
		rt(1'b1, 1'b0, 0, 8'hC3);
		wait_peer(base + 1, 8'hC3);
		ucb_serial_peer_i.send(8'h96);
		repeat (40) @(posedge clk);
		rr(0, 8'h96);
		$display("test polarity done");
		rt(1'b1, 1'b0, 7, 8'hAA);
		sb_n <= 1'b0;
		@(posedge clk);
		sb_n <= 1'b1;
		rr(7, 8'h00);
		cfg(1'b1, 8'hF0, 8'h05);
		rt(1'b1, 1'b0, 7, 8'hAA);
		sb_n <= 1'b0;
		@(posedge clk);
		sb_n <= 1'b1;
		rr(7, 8'hAA);
		sys_n <= 1'b0;
		@(posedge clk);
		sys_n <= 1'b1;
		rr(7, 8'h00);
		cfg(1'b1, 8'h30, 8'h00);
		rt(1'b0, 1'b0, 7, 8'h00);
		check("ack_off", 8'h00, {7'h00, a});
		$display("test reset select done");
		wrap_up();
	end
endmodule
`default_nettype wire
